// ### luic_params.svh
// Constants for the line unit interrupt control block.
// Assumes inclusion by name from every file that needs them.
`ifndef LUIC_PARAMS_SVH
`define LUIC_PARAMS_SVH

// Register indices within one channel window
`define LUIC_IDX_MASK_FIRST  6'h11
`define LUIC_IDX_MASK_SECOND 6'h12
`define LUIC_IDX_EDGE_SEL    6'h13
`define LUIC_IDX_LIVE_STAT   6'h14
`define LUIC_IDX_PEND_FIRST  6'h16
`define LUIC_IDX_PEND_SECOND 6'h17

// Byte address fields: index is address bits 7..2, channel 9..8
`define LUIC_IDX_LSB 2
`define LUIC_IDX_MSB 7
`define LUIC_CH_LSB  8
`define LUIC_CH_MSB  9

// Reset values
`define LUIC_MASK_FIRST_RST  7'h7f
`define LUIC_MASK_SECOND_RST 8'hff
`define LUIC_EDGE_SEL_RST    7'h00

// Field positions
`define LUIC_TXCLK_BIT 3
`define LUIC_FIRST_W   7
`define LUIC_SECOND_W  8

// Transmit clock idle limit in master clock cycles (70)
`define LUIC_TXCLK_LOSS_CYC 8'h46

// Bus answers
`define LUIC_RESP_OKAY   2'h0
`define LUIC_RESP_SLVERR 2'h2

`endif

// ### luic_pkg.sv
// Types shared by the line unit interrupt control files.
// Assumes nothing of its surroundings.
package luic_pkg;

   // Fifteen sources: second mask bits above first mask bits
   typedef logic [14:0] luic_src_t;

   // Seven real-time status bits of one channel
   typedef logic [6:0]  luic_stat_t;

endpackage : luic_pkg

// ### luic_event_chan.sv
// One channel: transmit clock watch, edge detection, pending flags.
// Assumes synchronous inputs and one-cycle pulses on pulse_in.
`timescale 1ns/1ns
`default_nettype none
`include "luic_params.svh"

module luic_event_chan
   import luic_pkg::*;
#(
   parameter int unsigned CNT_W = 7
)
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // Status sources, bit 3 slot omitted
   input  wire logic [5:0] status_in,
   input  wire logic       tx_clock_input,
   input  wire logic [7:0] pulse_in,
   // Configuration
   input  wire luic_src_t  irq_mask,
   input  wire luic_stat_t any_edge_sel,
   input  wire luic_src_t  pend_clr,
   // State
   output luic_stat_t      live_status,
   output luic_src_t       pending
);

   logic             clk_prev_reg;
   logic [CNT_W-1:0] idle_cnt_reg;
   logic             tx_clock_missing_status;
   luic_stat_t       prev_reg;
   luic_stat_t       edge_ev;
   luic_src_t        event_vec;

   // Idle cycle count of the transmit clock, saturating past limit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_prev_reg <= 1'b0;
         idle_cnt_reg <= '0;
      end
      else
      begin
         clk_prev_reg <= tx_clock_input;
         if (tx_clock_input != clk_prev_reg)
            idle_cnt_reg <= '0;
         else if (idle_cnt_reg <= CNT_W'(`LUIC_TXCLK_LOSS_CYC))
            idle_cnt_reg <= idle_cnt_reg + CNT_W'(1);
      end
   end

   // More than the limit without a toggle means clock lost
   assign tx_clock_missing_status =
      (idle_cnt_reg > CNT_W'(`LUIC_TXCLK_LOSS_CYC));

   // Live status and its one-cycle-old copy for edges
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         live_status <= '0;
         prev_reg    <= '0;
      end
      else
      begin
         live_status <= {status_in[5:3], tx_clock_missing_status,
                         status_in[2:0]};
         prev_reg    <= live_status;
      end
   end

   // Rise always counts; fall only where any-edge is selected
   assign edge_ev = (live_status & ~prev_reg) |
                    (any_edge_sel & prev_reg & ~live_status);
   assign event_vec = {pulse_in, edge_ev};

   // Only unmasked events latch; a set beats a same-cycle clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pending <= '0;
      else
         pending <= (pending & ~pend_clr) |
                    (event_vec & ~irq_mask);
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_loss_after_idle: assert property (
      tx_clock_missing_status |=> live_status[`LUIC_TXCLK_BIT])
      else $error("clock loss flag not raised after idle");

   a_loss_clears: assert property (
      $changed(tx_clock_input) |-> ##2 !live_status[`LUIC_TXCLK_BIT])
      else $error("clock loss flag held after toggle");

   a_masked_no_latch: assert property (
      1'b1 |=> ((pending & ~$past(pending) & $past(irq_mask)) == '0))
      else $error("masked event became pending");

   a_rise_latched: assert property (
      (live_status[0] && !prev_reg[0] && !irq_mask[0])
      |=> pending[0])
      else $error("unmasked rise not latched");

   a_level_fall_quiet: assert property (
      (!live_status[0] && prev_reg[0] && !any_edge_sel[0]
       && !pending[0]) |=> !pending[0])
      else $error("fall latched with rise-only select");

   a_any_fall_latched: assert property (
      (!live_status[1] && prev_reg[1] && any_edge_sel[1]
       && !irq_mask[1]) |=> pending[1])
      else $error("fall not latched with any-edge select");

endmodule : luic_event_chan
`default_nettype wire

// ### luic_line_irq.sv
// Four-channel interrupt control with an AXI4-Lite register slave.
// Assumes status inputs synchronous to aclk and a single clock.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "luic_params.svh"

module luic_line_irq
   import luic_pkg::*;
#(
   parameter int unsigned CHANNELS = 4,
   parameter int unsigned ADDR_W   = 10,
   parameter int unsigned CNT_W    = 7
)
(
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // Write address channel
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   // Write data channel
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // Write response channel
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // Read address channel
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   // Read data channel
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Line status, six per channel, bit 5 activate down to bit 0 loss
   input  wire logic [6*CHANNELS-1:0] line_status,
   // Transmit clock of each channel
   input  wire logic [CHANNELS-1:0]   tx_clock_input,
   // Event pulses, eight per channel in second mask order
   input  wire logic [8*CHANNELS-1:0] line_event,
   // Interrupt
   output logic                       irq
);

   // Held write address and data
   logic [ADDR_W-1:0] awaddr_reg;
   logic              aw_full_reg;
   logic [7:0]        wdata_reg;
   logic              wstrb0_reg;
   logic              w_full_reg;
   logic              aw_take;
   logic              w_take;
   logic              do_write;
   logic              aw_full_next;
   logic              w_full_next;
   logic [1:0]        wr_ch;
   logic [5:0]        wr_idx;
   logic              wr_hit;

   // Read decode
   logic [1:0]        rd_ch;
   logic [5:0]        rd_idx;
   logic [31:0]       rd_data;
   logic [1:0]        rd_resp;
   logic              ar_take;

   // Per-channel registers and state
   logic [`LUIC_FIRST_W-1:0]  mask_first_reg  [CHANNELS];
   logic [`LUIC_SECOND_W-1:0] mask_second_reg [CHANNELS];
   luic_stat_t                edge_sel_reg    [CHANNELS];
   luic_stat_t                live_stat       [CHANNELS];
   luic_src_t                 pend            [CHANNELS];
   luic_src_t                 pend_clr        [CHANNELS];
   logic [CHANNELS-1:0]       chan_irq;
   logic [CHANNELS-1:0]       chan_all_masked;

   // Handshake terms
   assign aw_take  = s_axi_awvalid & s_axi_awready;
   assign w_take   = s_axi_wvalid & s_axi_wready;
   assign do_write = aw_full_reg & w_full_reg & ~s_axi_bvalid;
   assign ar_take  = s_axi_arvalid & s_axi_arready;

   // Address and data may arrive in either order
   assign aw_full_next = (aw_full_reg | aw_take) & ~do_write;
   assign w_full_next  = (w_full_reg | w_take) & ~do_write;

   // Write field split of the held address
   assign wr_ch  = awaddr_reg[`LUIC_CH_MSB:`LUIC_CH_LSB];
   assign wr_idx = awaddr_reg[`LUIC_IDX_MSB:`LUIC_IDX_LSB];

   // Read field split straight from the offered address
   assign rd_ch  = s_axi_araddr[`LUIC_CH_MSB:`LUIC_CH_LSB];
   assign rd_idx = s_axi_araddr[`LUIC_IDX_MSB:`LUIC_IDX_LSB];

   // Write address holding slot
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awaddr_reg    <= '0;
         aw_full_reg   <= 1'b0;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         if (aw_take)
            awaddr_reg <= s_axi_awaddr;
         aw_full_reg   <= aw_full_next;
         s_axi_awready <= ~aw_full_next;
      end
   end

   // Write data holding slot; only the low byte lane matters
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wdata_reg    <= '0;
         wstrb0_reg   <= 1'b0;
         w_full_reg   <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         if (w_take)
         begin
            wdata_reg  <= s_axi_wdata[7:0];
            wstrb0_reg <= s_axi_wstrb[0];
         end
         w_full_reg   <= w_full_next;
         s_axi_wready <= ~w_full_next;
      end
   end

   // Known writable indices; others answer with a slave error
   always_comb
   begin
      case (wr_idx)
         `LUIC_IDX_MASK_FIRST,
         `LUIC_IDX_MASK_SECOND,
         `LUIC_IDX_EDGE_SEL,
         `LUIC_IDX_PEND_FIRST,
         `LUIC_IDX_PEND_SECOND: wr_hit = 1'b1;
         default:               wr_hit = 1'b0;
      endcase
   end

   // Write response, held until the master takes it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `LUIC_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? `LUIC_RESP_OKAY : `LUIC_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // Per-channel register copies and event logic
   generate
      for (genvar g = 0; g < CHANNELS; g++)
      begin : g_chan
         logic wr_here;

         // Channel field selects the copy, 40h indices apart
         assign wr_here = do_write & wstrb0_reg &
                          (wr_ch == 2'(g));

         // Mask and edge-select copies; reserved bit 7 dropped
         always_ff @(posedge aclk)
         begin
            if (!aresetn)
            begin
               mask_first_reg[g]  <= `LUIC_MASK_FIRST_RST;
               mask_second_reg[g] <= `LUIC_MASK_SECOND_RST;
               edge_sel_reg[g]    <= `LUIC_EDGE_SEL_RST;
            end
            else if (wr_here)
            begin
               if (wr_idx == `LUIC_IDX_MASK_FIRST)
                  mask_first_reg[g] <= wdata_reg[6:0];
               if (wr_idx == `LUIC_IDX_MASK_SECOND)
                  mask_second_reg[g] <= wdata_reg;
               if (wr_idx == `LUIC_IDX_EDGE_SEL)
                  edge_sel_reg[g] <= wdata_reg[6:0];
            end
         end

         // Writing a one clears that pending bit
         always_comb
         begin
            pend_clr[g] = '0;
            if (wr_here && wr_idx == `LUIC_IDX_PEND_FIRST)
               pend_clr[g][6:0] = wdata_reg[6:0];
            if (wr_here && wr_idx == `LUIC_IDX_PEND_SECOND)
               pend_clr[g][14:7] = wdata_reg;
         end

         luic_event_chan #(
            .CNT_W          (CNT_W)
         ) u_chan (
            .aclk           (aclk),
            .aresetn        (aresetn),
            .status_in      (line_status[6*g +: 6]),
            .tx_clock_input (tx_clock_input[g]),
            .pulse_in       (line_event[8*g +: 8]),
            .irq_mask       ({mask_second_reg[g], mask_first_reg[g]}),
            .any_edge_sel   (edge_sel_reg[g]),
            .pend_clr       (pend_clr[g]),
            .live_status    (live_stat[g]),
            .pending        (pend[g])
         );

         // Masking at the output too, so late masking silences it
         assign chan_irq[g] = |(pend[g] &
            ~{mask_second_reg[g], mask_first_reg[g]});
         assign chan_all_masked[g] = &{mask_second_reg[g],
                                       mask_first_reg[g]};
      end
   endgenerate

   // Read mux; reserved and upper bits read as zero
   always_comb
   begin
      rd_data = '0;
      rd_resp = `LUIC_RESP_OKAY;
      case (rd_idx)
         `LUIC_IDX_MASK_FIRST:  rd_data[6:0] = mask_first_reg[rd_ch];
         `LUIC_IDX_MASK_SECOND: rd_data[7:0] = mask_second_reg[rd_ch];
         `LUIC_IDX_EDGE_SEL:    rd_data[6:0] = edge_sel_reg[rd_ch];
         `LUIC_IDX_LIVE_STAT:   rd_data[6:0] = live_stat[rd_ch];
         `LUIC_IDX_PEND_FIRST:  rd_data[6:0] = pend[rd_ch][6:0];
         `LUIC_IDX_PEND_SECOND: rd_data[7:0] = pend[rd_ch][14:7];
         default:               rd_resp      = `LUIC_RESP_SLVERR;
      endcase
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `LUIC_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_data;
         s_axi_rresp   <= rd_resp;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   // One level output over all channels, registered
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |chan_irq;
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_answer: assert property (
      do_write |=> (s_axi_bvalid && s_axi_awready && s_axi_wready))
      else $error("write not answered next cycle");

   a_read_hold: assert property (
      (s_axi_rvalid && !s_axi_rready)
      |=> (s_axi_rvalid && $stable(s_axi_rdata)))
      else $error("read answer dropped or changed");

   a_read_answer: assert property (
      ar_take |=> (s_axi_rvalid && !s_axi_arready))
      else $error("read not answered next cycle");

   a_all_masked_quiet: assert property (
      (&chan_all_masked) |=> !irq)
      else $error("interrupt with every source masked");

   a_mask_store: assert property (
      (do_write && wstrb0_reg && wr_ch == 2'h0 &&
       wr_idx == `LUIC_IDX_MASK_FIRST)
      |=> mask_first_reg[0] == $past(wdata_reg[6:0]))
      else $error("first mask write not stored");

   a_edge_store: assert property (
      (do_write && wstrb0_reg && wr_ch == 2'h1 &&
       wr_idx == `LUIC_IDX_EDGE_SEL)
      |=> edge_sel_reg[1] == $past(wdata_reg[6:0]))
      else $error("edge select write not stored");

   a_second_store: assert property (
      (do_write && wstrb0_reg && wr_ch == 2'h3 &&
       wr_idx == `LUIC_IDX_MASK_SECOND)
      |=> mask_second_reg[3] == $past(wdata_reg))
      else $error("second mask write not stored");

   a_irq_follows: assert property (
      (|chan_irq) |=> irq)
      else $error("pending unmasked source without interrupt");

   a_reserved_zero: assert property (
      (ar_take && rd_idx == `LUIC_IDX_MASK_FIRST)
      |=> (s_axi_rdata[31:7] == '0))
      else $error("reserved mask bits read as one");

   a_unmapped_error: assert property (
      (do_write && !wr_hit) |=> (s_axi_bresp == `LUIC_RESP_SLVERR))
      else $error("unmapped write not refused");

endmodule : luic_line_irq
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the line unit interrupt control block.
// Assumes the design files are compiled first; the bench drives all ports.
`timescale 1ns/1ns
`default_nettype none
`include "luic_params.svh"

module tb_top;

   localparam int         LIMIT = 6000;
   localparam logic [5:0] IM1   = `LUIC_IDX_MASK_FIRST;
   localparam logic [5:0] IM2   = `LUIC_IDX_MASK_SECOND;
   localparam logic [5:0] IES   = `LUIC_IDX_EDGE_SEL;
   localparam logic [5:0] LIV   = `LUIC_IDX_LIVE_STAT;
   localparam logic [5:0] PD1   = `LUIC_IDX_PEND_FIRST;
   localparam logic [5:0] PD2   = `LUIC_IDX_PEND_SECOND;
   localparam logic [1:0] OK    = `LUIC_RESP_OKAY;
   localparam logic [1:0] SE    = `LUIC_RESP_SLVERR;

   logic        aclk, aresetn, irq;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, line_event;
   logic [3:0]  s_axi_wstrb, strb, tx_clock_input, tx_run;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [23:0] line_status;
   logic [7:0]  m;
   int          fails = 0, comparisons = 0, cycles = 0, r;

   // Device under test, default channel count and widths
   luic_line_irq #(.CHANNELS(4), .ADDR_W(10), .CNT_W(7)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .line_status(line_status),
      .tx_clock_input(tx_clock_input), .line_event(line_event),
      .irq(irq));

   // 10 MHz master clock
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // Transmit clocks toggle every cycle while their run bit is set
   always @(posedge aclk)
      tx_clock_input <= tx_clock_input ^ tx_run;

   // Hang guard: a stuck handshake ends the run as a failure
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fails++;
         stop_test();
      end
   end

   // Counts and reports one comparison
   task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : compare_word

   // Verdict and end of run
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test

   // Byte address of a register index in one channel window
   function automatic logic [9:0] ad(input int ch, input logic [5:0] idx);
      return {ch[1:0], idx, 2'b00};
   endfunction : ad

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [9:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= {24'h0, d};
      s_axi_wstrb   <= strb;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      compare_word({30'h0, s_axi_bresp}, {30'h0, er});
   endtask : wr

   // Read: rready held from the start until the answer is sampled
   task automatic rd(input logic [9:0] a, input logic [7:0] ed,
                     input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      compare_word(s_axi_rdata, {24'h0, ed});
      compare_word({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd

   // One-cycle event pulse, then time for pending and irq to settle
   task automatic pulse(input int n);
      @(posedge aclk);
      line_event <= 32'h1 << n;
      @(posedge aclk);
      line_event <= 32'h0;
      repeat (4) @(posedge aclk);
   endtask : pulse

   // New status levels, then time for the edge to reach pending
   task automatic stat(input logic [23:0] v);
      @(posedge aclk);
      line_status <= v;
      repeat (5) @(posedge aclk);
   endtask : stat

   // Main sequence
   initial
   begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
      strb = 4'h1;
      s_axi_wstrb = 4'h1;
      line_status = 24'h0;
      line_event = 32'h0;
      tx_clock_input = 4'h0;
      tx_run = 4'hf;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      compare_word({31'h0, irq}, 32'h0);
      // Reset values in every channel copy
      for (int c = 0; c < 4; c++)
      begin
         rd(ad(c, IM1), 8'h7f, OK);
         rd(ad(c, IM2), 8'hff, OK);
         rd(ad(c, IES), 8'h00, OK);
      end
      // Channel copies are independent; reserved bits read zero
      wr(ad(2, IM1), 8'h55, OK);
      rd(ad(2, IM1), 8'h55, OK);
      rd(ad(0, IM1), 8'h7f, OK);
      rd(ad(3, IM1), 8'h7f, OK);
      wr(ad(1, IES), 8'hff, OK);
      rd(ad(1, IES), 8'h7f, OK);
      wr(ad(1, IM1), 8'h80, OK);
      rd(ad(1, IM1), 8'h00, OK);
      strb = 4'h0;
      wr(ad(2, IM1), 8'h00, OK);
      strb = 4'h1;
      rd(ad(2, IM1), 8'h55, OK);
      wr(ad(2, IM1), 8'h7f, OK);
      wr(ad(1, IES), 8'h00, OK);
      wr(ad(1, IM1), 8'h7f, OK);
      // Unmapped index answers with an error and reads zero
      rd(ad(0, 6'h15), 8'h00, SE);
      wr(ad(0, 6'h15), 8'hff, SE);
      // Second mask: masked pulses are dropped, unmasked ones latch
      for (int b = 0; b < 8; b++)
      begin
         pulse(24 + b);
         compare_word({31'h0, irq}, 32'h0);
         rd(ad(3, PD2), 8'h00, OK);
         wr(ad(3, IM2), ~(8'h1 << b), OK);
         pulse(24 + b);
         compare_word({31'h0, irq}, 32'h1);
         rd(ad(3, PD2), 8'h1 << b, OK);
         wr(ad(3, PD2), 8'h1 << b, OK);
         rd(ad(3, PD2), 8'h00, OK);
         compare_word({31'h0, irq}, 32'h0);
         wr(ad(3, IM2), 8'hff, OK);
      end
      // Edge selects: rise only, then either edge, then masked
      for (int s = 0; s < 6; s++)
      begin
         r = (s < 3) ? s : s + 1;
         m = 8'h1 << r;
         wr(ad(0, IM1), 8'h7f & ~m, OK);
         stat(24'h1 << s);
         rd(ad(0, LIV), m, OK);
         rd(ad(0, PD1), m, OK);
         compare_word({31'h0, irq}, 32'h1);
         wr(ad(0, PD1), m, OK);
         stat(24'h0);
         rd(ad(0, PD1), 8'h00, OK);
         compare_word({31'h0, irq}, 32'h0);
         wr(ad(0, IES), m, OK);
         stat(24'h1 << s);
         rd(ad(0, PD1), m, OK);
         wr(ad(0, PD1), m, OK);
         stat(24'h0);
         rd(ad(0, PD1), m, OK);
         wr(ad(0, PD1), m, OK);
         wr(ad(0, IES), 8'h00, OK);
         wr(ad(0, IM1), 8'h7f, OK);
         stat(24'h1 << s);
         rd(ad(0, PD1), 8'h00, OK);
         stat(24'h0);
      end
      // Transmit clock loss on channel 1, any-edge events
      wr(ad(1, IM1), 8'h77, OK);
      wr(ad(1, IES), 8'h08, OK);
      @(posedge aclk);
      tx_run[1] <= 1'b0;
      repeat (55) @(posedge aclk);
      rd(ad(1, LIV), 8'h00, OK);
      repeat (25) @(posedge aclk);
      rd(ad(1, LIV), 8'h08, OK);
      rd(ad(1, PD1), 8'h08, OK);
      wr(ad(1, PD1), 8'h08, OK);
      @(posedge aclk);
      tx_run[1] <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(ad(1, LIV), 8'h00, OK);
      rd(ad(1, PD1), 8'h08, OK);
      // Second reset in mid-run restores defaults
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(ad(1, IM1), 8'h7f, OK);
      rd(ad(1, PD1), 8'h00, OK);
      compare_word({31'h0, irq}, 32'h0);
      stop_test();
   end

endmodule : tb_top
`default_nettype wire
